// ---- src/hbp_pkg.sv ----
// Package for the host buffer partition register group.
// Assumes an APB slave with 32-bit data; offsets are indices times four.
package hbp_pkg;

  // ----------------------------------------------------------------
  // Register indices (command codes) and address width
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_ISO_LEN_RD = 8'h2A;
  localparam logic [7:0] IDX_ISO_LEN_WR = 8'hAA;
  localparam logic [7:0] IDX_ASYNC_LEN_RD = 8'h2B;
  localparam logic [7:0] IDX_ASYNC_LEN_WR = 8'hAB;
  localparam logic [7:0] IDX_STATE_RD = 8'h2C;
  localparam logic [7:0] IDX_SOFT_RST_WR = 8'hA9;
  // Interrupt group
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC1;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hC2;

  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int ISO_ZERO_FILLED_BIT = 0;
  localparam int ISO_ONE_FILLED_BIT = 1;
  localparam int ASYNC_FILLED_BIT = 2;
  localparam int ISO_ZERO_CONSUMED_BIT = 3;
  localparam int ISO_ONE_CONSUMED_BIT = 4;
  localparam int ASYNC_CONSUMED_BIT = 5;
  localparam int STATE_W = 6;
  localparam logic [15:0] SOFT_RST_KEY = 16'h00F6;
  localparam logic [15:0] LEN_RESET = 16'h0000;
  localparam logic [5:0] STATE_RESET = 6'h00;
  localparam logic [15:0] RAM_BYTES = 16'h1000;

endpackage

// ---- src/hbp_flag_cell.sv ----
// One status flag: engine set and clear strobes, soft reset clears.
// Assumes strobes synchronous to pclk.
`timescale 1ns/1ps
module hbp_flag_cell (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_clr,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (soft_clr) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end

endmodule // hbp_flag_cell

// ---- src/hbp_regs.sv ----
// Register group that partitions the host transfer buffer RAM.
// Assumes an APB master on pclk and a host engine giving one-cycle flag strobes.
`timescale 1ns/1ps

// Overview of operation
// R1 - Writing F6H to the soft reset register resets all registers, not buffer RAM.
// R2 - One iso length write sizes both iso halves identically.
// R3 - Software keeps async length plus twice iso length within 1000H bytes.
// R4 - Iso length: 16-bit read/write, resets to zero, read 2AH write AAH.
// R5 - Async length: 16-bit read/write, resets to zero, read 2BH write ABH.
// R6 - Buffer status is read-only at 2CH, bits 15 to 6 reserved, resets zero.
// R7 - Status bit 5 shows the async buffer has been read by the engine.
// R8 - Status bits 4 and 3 show iso halves one and zero read.
// R9 - Status bit 2 shows the async buffer full.
// R10 - Status bits 1 and 0 show iso halves one and zero full.
// R11 - Soft reset register is 16-bit write-only at A9H, reads nothing.
// R12 - Writing any other value there changes no state.
module hbp_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] flag_set,
  input wire logic [5:0] flag_clr,
  output logic [15:0] iso_size_field,
  output logic [15:0] async_size_field,
  output logic size_overflow,
  output logic irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic [7:0] idx;
  logic addr_ok;
  logic mapped;
  logic soft_rst;
  logic [15:0] wdata16;
  logic [5:0] state_flags;
  logic [5:0] irq_status_q;
  logic [5:0] irq_enable_q;
  logic [31:0] rdata_d;
  logic wr_iso;
  logic wr_async;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic [5:0] state_rise;
  logic [5:0] state_prev_q;

  assign setup = psel && !penable;
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wdata16 = pwdata[15:0];

  always_comb begin
    mapped = 1'b0;
    if (addr_ok) begin
      if (pwrite) begin
        mapped = (idx == hbp_pkg::IDX_ISO_LEN_WR) || (idx == hbp_pkg::IDX_ASYNC_LEN_WR) ||
                 (idx == hbp_pkg::IDX_SOFT_RST_WR) || (idx == hbp_pkg::IDX_IRQ_ENABLE) ||
                 (idx == hbp_pkg::IDX_IRQ_CLEAR);
      end else begin
        mapped = (idx == hbp_pkg::IDX_ISO_LEN_RD) || (idx == hbp_pkg::IDX_ASYNC_LEN_RD) ||
                 (idx == hbp_pkg::IDX_STATE_RD) || (idx == hbp_pkg::IDX_IRQ_STATUS) ||
                 (idx == hbp_pkg::IDX_IRQ_ENABLE);
      end
    end
  end

  // Writes take effect at the edge that completes the access phase.
  assign wr_en = psel && penable && pready && pwrite && addr_ok && (pstrb[1:0] == 2'h3);
  assign wr_iso = wr_en && (idx == hbp_pkg::IDX_ISO_LEN_WR);
  assign wr_async = wr_en && (idx == hbp_pkg::IDX_ASYNC_LEN_WR);
  assign wr_irq_en = wr_en && (idx == hbp_pkg::IDX_IRQ_ENABLE);
  assign wr_irq_clr = wr_en && (idx == hbp_pkg::IDX_IRQ_CLEAR);
  assign soft_rst = wr_en && (idx == hbp_pkg::IDX_SOFT_RST_WR) &&
                    (wdata16 == hbp_pkg::SOFT_RST_KEY); // R1 R11 R12

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (setup && !pwrite && addr_ok) begin
      unique case (idx)
        hbp_pkg::IDX_ISO_LEN_RD: rdata_d[15:0] = iso_size_field; // R4
        hbp_pkg::IDX_ASYNC_LEN_RD: rdata_d[15:0] = async_size_field; // R5
        hbp_pkg::IDX_STATE_RD: rdata_d[5:0] = state_flags; // R6
        hbp_pkg::IDX_IRQ_STATUS: rdata_d[5:0] = irq_status_q;
        hbp_pkg::IDX_IRQ_ENABLE: rdata_d[5:0] = irq_enable_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Length registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iso_size_field <= hbp_pkg::LEN_RESET;
    end else if (soft_rst) begin
      iso_size_field <= hbp_pkg::LEN_RESET; // R1
    end else if (wr_iso) begin
      iso_size_field <= wdata16; // R2 R4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_size_field <= hbp_pkg::LEN_RESET;
    end else if (soft_rst) begin
      async_size_field <= hbp_pkg::LEN_RESET; // R1
    end else if (wr_async) begin
      async_size_field <= wdata16; // R5
    end
  end

  // Flags a partition that breaks the RAM budget; software must avoid it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_overflow <= 1'b0;
    end else begin
      size_overflow <= ({2'b00, async_size_field} + {1'b0, iso_size_field, 1'b0}) >
                       {2'b00, hbp_pkg::RAM_BYTES}; // R3
    end
  end

  // ----------------------------------------------------------------
  // Buffer status flags
  // ----------------------------------------------------------------
  // Bits 0..5: iso zero full, iso one full, async full, iso zero read,
  // iso one read, async read.
  genvar g;
  generate
    for (g = 0; g < hbp_pkg::STATE_W; g++) begin : g_flag
      hbp_flag_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .soft_clr(soft_rst),
        .set_i(flag_set[g]),
        .clr_i(flag_clr[g]),
        .flag_q(state_flags[g])
      ); // R7 R8 R9 R10
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_prev_q <= hbp_pkg::STATE_RESET;
    end else begin
      state_prev_q <= state_flags;
    end
  end

  assign state_rise = state_flags & ~state_prev_q;

  // A new event beats a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= hbp_pkg::STATE_RESET;
    end else if (soft_rst) begin
      irq_status_q <= hbp_pkg::STATE_RESET; // R1
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_irq_clr ? wdata16[5:0] : 6'h00)) | state_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= hbp_pkg::STATE_RESET;
    end else if (soft_rst) begin
      irq_enable_q <= hbp_pkg::STATE_RESET; // R1
    end else if (wr_irq_en) begin
      irq_enable_q <= wdata16[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

endmodule // hbp_regs

// ---- dv/hbp_engine_model.sv ----
// Host engine model: one-cycle strobes that fill and consume buffers.
// Assumes the bench calls its tasks between bus transfers.
`timescale 1ns/1ps
module hbp_engine_model (
  input wire logic pclk,
  output logic [5:0] flag_set,
  output logic [5:0] flag_clr
);
  initial begin
    flag_set = 6'h00;
    flag_clr = 6'h00;
  end
  task automatic pulse(input logic [5:0] s, input logic [5:0] c);
    @(posedge pclk);
    flag_set <= s;
    flag_clr <= c;
    @(posedge pclk);
    flag_set <= 6'h00;
    flag_clr <= 6'h00;
  endtask
  // Buffer 0/1 iso halves, 2 async; a refill also drops the consumed flag
  task automatic fill(input int b);
    pulse(6'h01 << b, 6'h08 << b);
  endtask
  task automatic drain(input int b);
    pulse(6'h08 << b, 6'h01 << b);
  endtask
endmodule // hbp_engine_model

// ---- dv/hbp_regs_assertions.sv ----
// Checker for the buffer partition register group.
// Assumes APB with setup at psel high and penable low.
`timescale 1ns/1ps
module hbp_regs_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] iso_size_field,
  input wire logic [15:0] async_size_field
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr;
    s_setup ##0 pwrite && pstrb[1:0] == 2'h3;
  endsequence
  sequence s_rd;
    s_setup ##0 !pwrite;
  endsequence
  sequence s_wr_done;
    psel && penable && pready && pwrite && pstrb[1:0] == 2'h3;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_READY: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_ISO_WR: assert property (s_wr_done ##0 paddr == 12'h2A8
    |=> iso_size_field == $past(pwdata[15:0])) else $error("iso length not written");
  AST_ASYNC_WR: assert property (s_wr_done ##0 paddr == 12'h2AC
    |=> async_size_field == $past(pwdata[15:0])) else $error("async length not written");
  AST_SOFT_RST: assert property (s_wr_done ##0 paddr == 12'h2A4 && pwdata[15:0] == 16'h00F6
    |=> iso_size_field == 16'h0000 && async_size_field == 16'h0000) else $error("no reset");
  AST_NO_RST: assert property (s_wr_done ##0 paddr == 12'h2A4 && pwdata[15:0] != 16'h00F6
    |=> $stable(iso_size_field) && $stable(async_size_field)) else $error("false reset");
  AST_ISO_RD: assert property (s_rd ##0 paddr == 12'h0A8
    |=> prdata == {16'h0000, $past(iso_size_field)}) else $error("iso read wrong");
  AST_STAT_RD: assert property (s_rd ##0 paddr == 12'h0B0
    |=> prdata[31:6] == 26'h0000000 && !pslverr) else $error("status reserved bits set");
  AST_STAT_RO: assert property (s_wr ##0 paddr == 12'h0B0 |=> pslverr)
    else $error("status write accepted");
  AST_SRST_WO: assert property (s_rd ##0 paddr == 12'h2A4 |=> pslverr)
    else $error("soft reset read accepted");
endmodule // hbp_regs_assertions
bind hbp_regs hbp_regs_assertions hbp_regs_assertions_i (.*);

// ---- dv/hbp_regs_bench.sv ----
// Bench for the buffer partition registers: APB tasks and engine model.
// Assumes an APB slave that may insert wait states; bound checker runs alongside.
`timescale 1ns/1ps
module hbp_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, size_overflow, irq, er_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0] pstrb;
  logic [5:0] flag_set, flag_clr, st;
  logic [15:0] iso_size_field, async_size_field;
  int fail_count, n_compared;
  hbp_regs hbp_regs_i (.*);
  hbp_engine_model hbp_engine_model_i (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      $display("Error t=%0t seen %h exp %h", $time, s, e);
      fail_count++;
    end
  endtask
  task automatic xf(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    er_q = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic rx(input logic [11:0] a, input logic [31:0] e);
    xf(a, 1'b0, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rx(12'h0A8, 32'h0);
    rx(12'h0AC, 32'h0);
    rx(12'h0B0, 32'h0);
    $display("test reset done");
    xf(12'h2A8, 1'b1, 32'hFFFF0400);
    xf(12'h2AC, 1'b1, 32'h00000800);
    rx(12'h0A8, 32'h400);
    chk({16'h0, iso_size_field}, 32'h400);
    rx(12'h0AC, 32'h800);
    chk(size_overflow, 0);
    xf(12'h2A8, 1'b1, 32'h401);
    settle();
    chk(size_overflow, 1);
    xf(12'h2A8, 1'b1, 32'h400);
    settle();
    chk(size_overflow, 0);
    $display("test lengths done");
    st = 6'h00;
    for (int b = 0; b < 3; b++) begin
      hbp_engine_model_i.fill(b);
      st[b] = 1'b1;
      rx(12'h0B0, {26'h0, st});
      hbp_engine_model_i.drain(b);
      st[b] = 1'b0;
      st[b+3] = 1'b1;
      rx(12'h0B0, {26'h0, st});
    end
    xf(12'h0B0, 1'b1, 32'hFFFF);
    chk(er_q, 1);
    rx(12'h0B0, {26'h0, st});
    xf(12'h2A4, 1'b0, 32'h0);
    chk(er_q, 1);
    $display("test status done");
    xf(12'h308, 1'b1, 32'h3F);
    hbp_engine_model_i.fill(0);
    rx(12'h300, 32'h1);
    settle();
    chk(irq, 0);
    xf(12'h304, 1'b1, 32'h1);
    settle();
    chk(irq, 1);
    xf(12'h308, 1'b1, 32'h1);
    settle();
    chk(irq, 0);
    rx(12'h300, 32'h0);
    $display("test irq done");
    xf(12'h2A4, 1'b1, 32'h1234);
    rx(12'h0A8, 32'h400);
    rx(12'h0B0, 32'h31);
    xf(12'h304, 1'b1, 32'h1);
    xf(12'h2A4, 1'b1, 32'hF6);
    rx(12'h0A8, 32'h0);
    rx(12'h0AC, 32'h0);
    rx(12'h0B0, 32'h0);
    rx(12'h304, 32'h0);
    $display("test soft reset done");
    give_verdict();
  end
endmodule // hbp_regs_bench
